// File: hw/fsled_encoder.v
// Status indicator encoder for the first output word of the shift chain channel.
// Assumes software reports system state through the register port and a
// shift chain engine downstream takes the word from chain_word.
//
// Behaviour
// - Display mode puts indicators in low bits
// - Bit 0 low idle, high running
// - Bit 0 flashes during initialisation, bit 4 flickers during autobaud
// - Bit 1 flashes on configuration error
// - Fatal error: bit 1 high, logged
// - Bit 5 high while bus off
// - Bit 5 single-flashes at warning limit
`timescale 1ns/1ps
`default_nettype none
`include "fsled_defines.vh"

module fsled_encoder #(
   parameter [31:0] flicker_cyc = `FSLED_FLICKER_CYC,
   parameter [31:0] flash_cyc = `FSLED_FLASH_CYC,
   parameter [31:0] single_cyc = `FSLED_SINGLE_CYC
) (
   input wire clk_sys,
   input wire resetn,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg [15:0] chain_word,
   output reg irq,
   output reg fatal_log
);

   reg disp_en; // Display function selected
   reg [15:0] sys_state; // System state written by software
   reg [15:0] pdata; // Process data for the first word
   reg [`FSLED_IRQ_W-1:0] irq_stat; // Sticky event flags
   reg [`FSLED_IRQ_W-1:0] irq_mask; // Event enables
   reg [`FSLED_IRQ_W-1:0] prev_ev; // Last event levels for edge detect
   reg [5:0] next_ind; // Indicator bits being composed
   reg [15:0] next_word; // Word bound for the chain
   wire [`FSLED_IRQ_W-1:0] ev_lvl; // Event levels
   wire [`FSLED_IRQ_W-1:0] ev_rise; // Event onsets
   wire [2:0] fb_state; // Fieldbus node state field
   wire wave_flicker; // Fast blink
   wire wave_flash; // Normal blink
   wire wave_single; // One short flash per frame

   assign fb_state = sys_state[`FSLED_ST_FB_HI:`FSLED_ST_FB_LO];

   // Shared blink timing keeps all LEDs in phase with each other
   fsled_blink #(
      .flicker_cyc(flicker_cyc),
      .flash_cyc(flash_cyc),
      .single_cyc(single_cyc)
   ) u_blink (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .flicker(wave_flicker),
      .flash(wave_flash),
      .single(wave_single)
   );

   // Events that raise interrupts
   assign ev_lvl[`FSLED_IRQ_FATAL] = sys_state[`FSLED_ST_FATAL];
   assign ev_lvl[`FSLED_IRQ_BUSOFF] = sys_state[`FSLED_ST_BUS_OFF];
   assign ev_lvl[`FSLED_IRQ_WARN] = sys_state[`FSLED_ST_WARN];
   assign ev_lvl[`FSLED_IRQ_CFGERR] = sys_state[`FSLED_ST_CFG_ERR];
   assign ev_rise = ev_lvl & ~prev_ev;

   // Indicator composition; priority picks the most severe state per LED
   always @* begin
      next_ind = 6'h00;
      // Module operation: init flashes over run, nothing means off
      if (sys_state[`FSLED_ST_MOD_INIT]) begin
         next_ind[0] = wave_flash;
      end else if (sys_state[`FSLED_ST_MOD_RUN]) begin
         next_ind[0] = 1'b1;
      end else begin
         next_ind[0] = 1'b0;
      end
      // Module error: fatal beats configuration error
      if (sys_state[`FSLED_ST_FATAL]) begin
         next_ind[1] = 1'b1;
      end else if (sys_state[`FSLED_ST_CFG_ERR]) begin
         next_ind[1] = wave_flash;
      end else begin
         next_ind[1] = 1'b0;
      end
      // Script state
      next_ind[2] = sys_state[`FSLED_ST_SCR_RUN] ? 1'b1 : wave_flash;
      next_ind[3] = sys_state[`FSLED_ST_SCR_ERR];
      // Fieldbus node state
      case (fb_state)
         `FSLED_FB_OFF: next_ind[4] = 1'b0;
         `FSLED_FB_OPER: next_ind[4] = 1'b1;
         `FSLED_FB_STOP: next_ind[4] = wave_single;
         `FSLED_FB_PREOP: next_ind[4] = wave_flash;
         `FSLED_FB_AUTOBAUD: next_ind[4] = wave_flicker;
         default: next_ind[4] = 1'b0;
      endcase
      // Fieldbus error: bus off outranks the warning limit
      if (sys_state[`FSLED_ST_BUS_OFF]) begin
         next_ind[5] = 1'b1;
      end else if (sys_state[`FSLED_ST_WARN]) begin
         next_ind[5] = wave_single;
      end else begin
         next_ind[5] = 1'b0;
      end
      // Upper bits keep process data so outside LEDs see the rest untouched
      if (disp_en) begin
         next_word = {pdata[15:6], next_ind};
      end else begin
         next_word = pdata;
      end
   end

   // Register writes, sticky flags and the output word
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         disp_en <= `FSLED_CTRL_RST;
         sys_state <= `FSLED_ST_RST;
         pdata <= 16'h0000;
         irq_stat <= {`FSLED_IRQ_W{1'b0}};
         irq_mask <= {`FSLED_IRQ_W{1'b0}};
         prev_ev <= {`FSLED_IRQ_W{1'b0}};
         chain_word <= 16'h0000;
         irq <= 1'b0;
         fatal_log <= 1'b0;
      end else begin
         prev_ev <= ev_lvl;
         chain_word <= next_word;
         // Write decode; unmapped addresses are ignored
         if (reg_wr) begin
            case (reg_addr)
               `FSLED_ADDR_CTRL: disp_en <= reg_wdata[`FSLED_CTRL_DISP_BIT];
               `FSLED_ADDR_STATE: sys_state <= reg_wdata;
               `FSLED_ADDR_IRQ_MASK: irq_mask <= reg_wdata[`FSLED_IRQ_W-1:0];
               `FSLED_ADDR_PDATA: pdata <= reg_wdata;
               default: ;
            endcase
         end
         // Write-one-to-clear; a new event in the same cycle wins
         if (reg_wr && reg_addr == `FSLED_ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~reg_wdata[`FSLED_IRQ_W-1:0]) | ev_rise;
         end else begin
            irq_stat <= irq_stat | ev_rise;
         end
         // Fatal onset pulses into the error stack
         fatal_log <= ev_rise[`FSLED_IRQ_FATAL];
         irq <= |(irq_stat & irq_mask);
      end
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `FSLED_ADDR_CTRL: reg_rdata <= {15'h0000, disp_en};
            `FSLED_ADDR_STATE: reg_rdata <= sys_state;
            `FSLED_ADDR_IRQ_STAT: reg_rdata <= {12'h000, irq_stat};
            `FSLED_ADDR_IRQ_MASK: reg_rdata <= {12'h000, irq_mask};
            `FSLED_ADDR_WORD: reg_rdata <= chain_word;
            `FSLED_ADDR_PDATA: reg_rdata <= pdata;
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule // fsled_encoder

`default_nettype wire

// File: hw/fsled_defines.vh
// Constants for the fieldbus status indicator encoder.
// Included by the encoder, its checker and its bench; definitions only.
`ifndef FSLED_DEFINES_VH
`define FSLED_DEFINES_VH

// Register offsets (word index on the plain register port)
`define FSLED_ADDR_CTRL 4'h0
`define FSLED_ADDR_STATE 4'h1
`define FSLED_ADDR_IRQ_STAT 4'h2
`define FSLED_ADDR_IRQ_MASK 4'h3
`define FSLED_ADDR_WORD 4'h4
`define FSLED_ADDR_PDATA 4'h5
// Configuration register number that selects the display function
`define FSLED_CFG_REG_NUM 16'h0025

// Control register fields
`define FSLED_CTRL_DISP_BIT 0
`define FSLED_CTRL_RST 1'b0

// State register fields (software reports system state here)
`define FSLED_ST_MOD_RUN 0
`define FSLED_ST_MOD_INIT 1
`define FSLED_ST_CFG_ERR 2
`define FSLED_ST_FATAL 3
`define FSLED_ST_SCR_RUN 4
`define FSLED_ST_SCR_ERR 5
`define FSLED_ST_BUS_OFF 6
`define FSLED_ST_WARN 7
`define FSLED_ST_FB_LO 8
`define FSLED_ST_FB_HI 10
`define FSLED_ST_RST 16'h0000

// Fieldbus node states in the state register
`define FSLED_FB_OFF 3'h0
`define FSLED_FB_OPER 3'h1
`define FSLED_FB_STOP 3'h2
`define FSLED_FB_PREOP 3'h3
`define FSLED_FB_AUTOBAUD 3'h4

// Interrupt status bits
`define FSLED_IRQ_FATAL 0
`define FSLED_IRQ_BUSOFF 1
`define FSLED_IRQ_WARN 2
`define FSLED_IRQ_CFGERR 3
`define FSLED_IRQ_W 4

// Blink timing, flicker and flash half periods and single frame in microseconds, clock period in ns
`define FSLED_CLK_NS 4
`define FSLED_FLICKER_US 50000
`define FSLED_FLASH_US 200000
`define FSLED_SINGLE_US 1000000
`define FSLED_FLICKER_CYC (`FSLED_FLICKER_US * 1000 / `FSLED_CLK_NS)
`define FSLED_FLASH_CYC (`FSLED_FLASH_US * 1000 / `FSLED_CLK_NS)
`define FSLED_SINGLE_CYC (`FSLED_SINGLE_US * 1000 / `FSLED_CLK_NS)

// Single-flash on time equals one flash half period
`define FSLED_CNT_W 32

`endif

// File: hw/fsled_blink.v
// Blink pattern generator: flicker, flash and single-flash waveforms.
// Assumes one free running clock; periods are module parameters.
`timescale 1ns/1ps
`default_nettype none

module fsled_blink #(
   parameter [31:0] flicker_cyc = 32'd12500000,
   parameter [31:0] flash_cyc = 32'd50000000,
   parameter [31:0] single_cyc = 32'd250000000
) (
   input wire clk_sys,
   input wire resetn,
   output reg flicker,
   output reg flash,
   output reg single
);

   reg [31:0] cnt_flk; // Flicker half period counter
   reg [31:0] cnt_fl; // Flash half period counter
   reg [31:0] cnt_sg; // Single-flash frame counter

   // Flicker and flash toggle at their own half periods; single is on for one flash half period
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_flk <= 32'h0;
         cnt_fl <= 32'h0;
         cnt_sg <= 32'h0;
         flicker <= 1'b0;
         flash <= 1'b0;
         single <= 1'b0;
      end else begin
         if (cnt_flk >= flicker_cyc - 32'h1) begin
            cnt_flk <= 32'h0;
            flicker <= ~flicker;
         end else begin
            cnt_flk <= cnt_flk + 32'h1;
         end
         if (cnt_fl >= flash_cyc - 32'h1) begin
            cnt_fl <= 32'h0;
            flash <= ~flash;
         end else begin
            cnt_fl <= cnt_fl + 32'h1;
         end
         if (cnt_sg >= single_cyc - 32'h1) begin
            cnt_sg <= 32'h0;
         end else begin
            cnt_sg <= cnt_sg + 32'h1;
         end
         // Short pulse at the start of each long frame
         single <= (cnt_sg < flash_cyc);
      end
   end

endmodule // fsled_blink

`default_nettype wire

// File: verif/fsled_chain_sink.sv
// Model of the external shift chain that drives the indicator LEDs.
// Assumes the chain delivers one whole word per system clock.
`timescale 1ns/1ps
`default_nettype none
module fsled_chain_sink (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [15:0] chain_word,
   output logic [15:0] led
);
   // LEDs take their drive from the shifted word, one clock late
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) led <= 16'h0000;
      else led <= chain_word;
   end
endmodule // fsled_chain_sink
`default_nettype wire

// File: verif/fsled_encoder_assertions.sv
// Port checker for the status encoder, bound to fsled_encoder.
// Assumes registers change only through the register port.
`timescale 1ns/1ps
`default_nettype none
`include "fsled_defines.vh"
module fsled_encoder_assertions #(
   parameter [31:0] flicker_cyc = 32'd4,
   parameter [31:0] flash_cyc = 32'd8,
   parameter [31:0] single_cyc = 32'd40
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [15:0] chain_word,
   input wire logic irq,
   input wire logic fatal_log
);
   logic disp; // Shadow of display enable
   logic [15:0] st, pd; // Shadows of state and process data
   // Shadows follow writes, so chain_word lags them by one clock
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         disp <= 1'b0;
         st <= 16'h0000;
         pd <= 16'h0000;
      end else if (reg_wr) begin
         if (reg_addr == `FSLED_ADDR_CTRL) disp <= reg_wdata[0];
         if (reg_addr == `FSLED_ADDR_STATE) st <= reg_wdata;
         if (reg_addr == `FSLED_ADDR_PDATA) pd <= reg_wdata;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence s_fatal_rise;
      $rose(st[3]);
   endsequence
   AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside its slot");
   AST_PASS: assert property ($past(!disp) |-> chain_word == $past(pd))
      else $error("word not process data");
   AST_HI: assert property (chain_word[15:6] == $past(pd[15:6]))
      else $error("upper bits not process data");
   AST_RUN: assert property ($past(disp && st[0] && !st[1]) |-> chain_word[0])
      else $error("operation bit not on");
   AST_IDLE: assert property ($past(disp && !st[0] && !st[1]) |-> !chain_word[0])
      else $error("operation bit not off");
   AST_FATAL_ON: assert property ($past(disp && st[3]) |-> chain_word[1])
      else $error("error bit not on");
   AST_FATAL_LOG: assert property (s_fatal_rise |-> ##[0:2] fatal_log)
      else $error("fatal not logged");
   AST_SCRIPT: assert property ($past(disp) |-> chain_word[3] == $past(st[5]))
      else $error("script error bit wrong");
   AST_BUSOFF: assert property ($past(disp && st[6]) |-> chain_word[5])
      else $error("bus off bit not on");
   AST_OPER: assert property ($past(disp && st[10:8] == 3'h1) |-> chain_word[4])
      else $error("node run bit not on");
endmodule // fsled_encoder_assertions
bind fsled_encoder fsled_encoder_assertions #(.flicker_cyc(flicker_cyc),
   .flash_cyc(flash_cyc), .single_cyc(single_cyc)) u_chk (.*);
`default_nettype wire

// File: verif/fsled_encoder_tb.sv
// Self-checking bench for the status encoder with a shift chain model.
// Assumes short blink periods 8, 16 and 40 clocks.
`timescale 1ns/1ps
`default_nettype none
`include "fsled_defines.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module fsled_encoder_tb;
   logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, st, pd, d;
   wire [15:0] reg_rdata, chain_word, led;
   wire irq, fatal_log;
   int failures = 0, comparisons = 0, seed = 32'h3265fa11, nlog = 0;
   int h[6], t[6];
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (fatal_log === 1'b1) nlog++;
   fsled_encoder #(.flicker_cyc(32'd4), .flash_cyc(32'd8), .single_cyc(32'd40)) u_fsled_encoder (
      .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chain_word(chain_word),
      .irq(irq), .fatal_log(fatal_log));
   fsled_chain_sink u_fsled_chain_sink (.clk_sys(clk_sys), .resetn(resetn),
      .chain_word(chain_word), .led(led));
   // One-cycle write, then one idle cycle so strobes never collide
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
      @(posedge clk_sys); reg_wr <= 1'b0; @(posedge clk_sys);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk_sys); reg_rd <= 1'b0; #1 v = reg_rdata; @(posedge clk_sys);
   endtask
   // Pattern kind per bit: 0 off, 1 on, 2 flash, 3 flicker, 4 single flash
   function automatic int kind(input int b, input logic [15:0] s);
      case (b)
         0: return s[1] ? 2 : s[0] ? 1 : 0;
         1: return s[3] ? 1 : s[2] ? 2 : 0;
         2: return s[4] ? 1 : 2;
         3: return s[5] ? 1 : 0;
         4: case (s[10:8]) 1: return 1; 2: return 4; 3: return 2; 4: return 3; default: return 0; endcase
         default: return s[6] ? 1 : s[7] ? 4 : 0;
      endcase
   endfunction
   // High count times 100 plus edges, over 80 clocks
   function automatic int pcode(input int k);
      case (k) 0: return 0; 1: return 8000; 2: return 4010; 3: return 4020; default: return 1604; endcase
   endfunction
   task automatic measure;
      logic [15:0] prev;
      for (int b = 0; b < 6; b++) begin h[b] = 0; t[b] = 0; end
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 81; i++) begin
         @(posedge clk_sys); #1;
         for (int b = 0; b < 6; b++) begin
            if (i < 80 && led[b] === 1'b1) h[b]++;
            if (i > 0 && led[b] !== prev[b]) t[b]++;
         end
         prev = led;
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog well beyond the roughly 1500 clocks the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1; @(posedge clk_sys);
      pd = $random(seed); wr(`FSLED_ADDR_PDATA, pd); wr(`FSLED_ADDR_CTRL, 16'h0000);
      repeat (3) @(posedge clk_sys);
      `CHK(led, pd)
      $display("pass-through test done");
      wr(`FSLED_ADDR_CTRL, 16'h0001);
      // Every node state twice, other state bits random
      for (int k = 0; k < 16; k++) begin
         d = $random(seed); st = {5'h00, k[2:0], d[7:0]};
         wr(`FSLED_ADDR_STATE, st); rd(`FSLED_ADDR_STATE, d);
         `CHK(d, st)
         measure();
         for (int b = 0; b < 6; b++) `CHK(h[b] * 100 + t[b], pcode(kind(b, st)))
         `CHK(led[15:6], pd[15:6])
      end
      $display("pattern test done");
      wr(`FSLED_ADDR_STATE, 16'h0000); wr(`FSLED_ADDR_IRQ_STAT, 16'hffff);
      wr(`FSLED_ADDR_IRQ_MASK, 16'h000f); nlog = 0;
      wr(`FSLED_ADDR_STATE, 16'h0008); repeat (3) @(posedge clk_sys);
      `CHK(nlog, 1)
      `CHK(irq, 1'b1)
      rd(`FSLED_ADDR_IRQ_STAT, d);
      `CHK(d, 16'h0001)
      wr(`FSLED_ADDR_IRQ_MASK, 16'h0000); @(posedge clk_sys);
      `CHK(irq, 1'b0)
      wr(`FSLED_ADDR_IRQ_STAT, 16'h0001); rd(`FSLED_ADDR_IRQ_STAT, d);
      `CHK(d, 16'h0000)
      rd(4'hf, d);
      `CHK(d, 16'h0000)
      // Steady states only, so the read-back word is fixed: run, script run and error,
      // bus off and node operational
      wr(`FSLED_ADDR_STATE, 16'h0171); rd(`FSLED_ADDR_WORD, d);
      `CHK(d, {pd[15:6], 6'h3d})
      rd(`FSLED_ADDR_IRQ_STAT, d);
      `CHK(d, 16'h0002)
      $display("interrupt and map test done");
      conclude();
   end
endmodule // fsled_encoder_tb
`default_nettype wire
